// >>> design/sspi_pkg.sv
// Package of constants shared by both ends of the switch serial port
package sspi_pkg;
  localparam int unsigned WORD_BITS    = 8;
  localparam int unsigned CNT_W        = 3;
  localparam logic [7:0]  STATUS_RST   = 8'h00;
  localparam logic [7:0]  WORD_RST     = 8'h00;
  localparam logic [2:0]  CNT_RST      = 3'h0;
  // Command field positions
  localparam int unsigned WD_BIT       = 7;
  localparam int unsigned ADDR_HI      = 6;
  localparam int unsigned ADDR_LO      = 4;
  localparam int unsigned CFG_HI       = 3;
  localparam int unsigned CFG_LO       = 0;
  // Host serial clock divider: half period in system clocks
  // Eight clocks per half period: the device's two-flop synchroniser and
  // registered output, plus the host's own synchroniser on the return line,
  // take five clocks, so the bit must settle well before the host samples
  localparam int unsigned SCK_HALF     = 8;
  localparam logic [3:0]  DIV_RST      = 4'h0;
  localparam logic [3:0]  DIV_LAST     = 4'(SCK_HALF - 1);
  // Host idle clocks with select low before and after the clock edges, and with select high after a frame
  localparam logic [3:0]  GAP_LAST     = 4'h3;
endpackage

// >>> design/sspi_if.sv
// Interface joining the switch serial port to its host
`timescale 1ns/1ps
interface sspi_if;
  logic sck;
  logic csN;
  logic mosi;
  logic misoO;
  logic misoOe;
  modport dev (
    input  sck,
    input  csN,
    input  mosi,
    output misoO,
    output misoOe
  );
  modport host (
    output sck,
    output csN,
    output mosi,
    input  misoO,
    input  misoOe
  );
endinterface

// >>> design/sspi_device.sv
// Device end: serial slave port of the dual high-side switch
`timescale 1ns/1ps
module sspi_device (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Link to the host
  sspi_if.dev             link,
  // Status word presented for the first output word
  input  wire logic [7:0] statusIn,
  // Latched command
  output logic            cmdValid,
  output logic            cmdWd,
  output logic [3:0]      cmdAddr,
  output logic [2:0]      cmdReg,
  output logic [3:0]      cmdCfg
);
  typedef struct packed {
    logic [1:0] sckSy;
    logic [1:0] csSy;
    logic [1:0] siSy;
    logic       sckQ;
    logic       csQ;
    logic [7:0] shift;
    logic [2:0] cnt;
    logic       aligned;
    logic       selected;
    logic       outBit;
    logic       valid;
    logic [7:0] cmd;
  } sspi_dev_s;

  sspi_dev_s st_r;
  sspi_dev_s st_nxt;

  logic sck;
  logic cs;
  logic si;
  assign sck = st_r.sckSy[1];
  assign cs  = st_r.csSy[1];
  assign si  = st_r.siSy[1];

  // Next state; pins are synchronised before use since the link is slow
  always_comb begin
    st_nxt       = st_r;
    st_nxt.valid = 1'b0;
    st_nxt.sckSy = {st_r.sckSy[0], link.sck};
    st_nxt.csSy  = {st_r.csSy[0], link.csN};
    st_nxt.siSy  = {st_r.siSy[0], link.mosi};
    st_nxt.sckQ  = sck;
    st_nxt.csQ   = cs;
    if (cs) begin
      // Deselected: clock and input ignored
      st_nxt.cnt      = sspi_pkg::CNT_RST;
      st_nxt.selected = 1'b0;
      if (!st_r.csQ && st_r.aligned) begin
        // Select rise with whole words only
        st_nxt.valid = 1'b1;
        st_nxt.cmd   = st_r.shift;
      end
      st_nxt.aligned = 1'b0;
    end else if (st_r.csQ) begin
      // Select fall: status into the shifter, first bit out
      st_nxt.shift    = statusIn;
      st_nxt.outBit   = statusIn[7];
      st_nxt.selected = 1'b1;
    end else begin
      if (!sck && st_r.sckQ) begin
        // Falling edge: capture input, MSB first
        st_nxt.shift   = {st_r.shift[6:0], si};
        st_nxt.cnt     = st_r.cnt + 3'h1;
        st_nxt.aligned = (st_r.cnt == 3'h7);
      end
      if (sck && !st_r.sckQ && st_r.aligned | (st_r.cnt != 3'h0)) begin
        // Rising edge after first: present next bit
        st_nxt.outBit = st_r.shift[7];
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{sckSy: 2'h0, csSy: 2'h3, siSy: 2'h0, sckQ: 1'b0,
                csQ: 1'b1, shift: sspi_pkg::WORD_RST,
                cnt: sspi_pkg::CNT_RST, aligned: 1'b0,
                selected: 1'b0, outBit: 1'b0, valid: 1'b0,
                cmd: sspi_pkg::WORD_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output drive and command fields
  assign link.misoO  = st_r.selected ? st_r.outBit : 1'b0;
  assign link.misoOe = st_r.selected;
  assign cmdValid = st_r.valid;
  assign cmdWd    = st_r.cmd[sspi_pkg::WD_BIT];
  assign cmdAddr  = st_r.cmd[7:4];
  assign cmdReg   = st_r.cmd[sspi_pkg::ADDR_HI:sspi_pkg::ADDR_LO];
  assign cmdCfg   = st_r.cmd[sspi_pkg::CFG_HI:sspi_pkg::CFG_LO];
endmodule

// >>> design/sspi_host.sv
// Host end: serial bus master for the switch port
`timescale 1ns/1ps
module sspi_host (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Link to the device
  sspi_if.host            link,
  // Request: one 8-bit word per frame
  input  wire logic       reqValid,
  input  wire logic [7:0] reqData,
  output logic            reqReady,
  // Answer
  output logic            rspValid,
  output logic [7:0]      rspData
);
  typedef enum logic [2:0] {IDLE, LEAD, SHIFT, TAIL, GAP} sspi_hst_e;
  typedef struct packed {
    sspi_hst_e  state;
    logic [1:0] soSy;
    logic [3:0] div;
    logic [2:0] bitN;
    logic       sck;
    logic       csN;
    logic [7:0] tx;
    logic [7:0] rx;
    logic       rv;
    logic [7:0] rd;
  } sspi_hst_s;

  sspi_hst_s st_r;
  sspi_hst_s st_nxt;

  // Divider and sequencer; clock held low around every select edge
  always_comb begin
    st_nxt      = st_r;
    st_nxt.rv   = 1'b0;
    st_nxt.soSy = {st_r.soSy[0], link.misoO};
    st_nxt.div  = st_r.div + 4'h1;
    unique case (st_r.state)
      IDLE: begin
        st_nxt.div = sspi_pkg::DIV_RST;
        if (reqValid) begin
          st_nxt.tx    = reqData;
          st_nxt.csN   = 1'b0;
          st_nxt.state = LEAD;
        end
      end
      LEAD: begin
        if (st_r.div == sspi_pkg::GAP_LAST) begin
          st_nxt.div   = sspi_pkg::DIV_RST;
          st_nxt.bitN  = 3'h0;
          st_nxt.state = SHIFT;
        end
      end
      SHIFT: begin
        if (st_r.div == sspi_pkg::DIV_LAST) begin
          st_nxt.div = sspi_pkg::DIV_RST;
          st_nxt.sck = !st_r.sck;
          if (!st_r.sck && (st_r.bitN != 3'h0)) begin
            // Rising edge after the first: next bit out, half a period
            // ahead of the device's sampling edge
            st_nxt.tx = {st_r.tx[6:0], 1'b0};
          end
          if (st_r.sck) begin
            // Falling edge: device samples, host captures MSB first
            st_nxt.rx   = {st_r.rx[6:0], st_r.soSy[1]};
            st_nxt.bitN = st_r.bitN + 3'h1;
            if (st_r.bitN == 3'h7) begin
              st_nxt.state = TAIL;
            end
          end
        end
      end
      TAIL: begin
        if (st_r.div == sspi_pkg::GAP_LAST) begin
          st_nxt.csN   = 1'b1;
          st_nxt.rv    = 1'b1;
          st_nxt.rd    = st_r.rx;
          st_nxt.div   = sspi_pkg::DIV_RST;
          st_nxt.state = GAP;
        end
      end
      GAP: begin
        if (st_r.div == sspi_pkg::GAP_LAST) begin
          st_nxt.state = IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: IDLE, soSy: 2'h0, div: sspi_pkg::DIV_RST,
                bitN: 3'h0, sck: 1'b0, csN: 1'b1,
                tx: sspi_pkg::WORD_RST, rx: sspi_pkg::WORD_RST,
                rv: 1'b0, rd: sspi_pkg::WORD_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Link and user outputs
  assign link.sck  = st_r.sck;
  assign link.csN  = st_r.csN;
  assign link.mosi = st_r.tx[7];
  assign reqReady  = (st_r.state == IDLE);
  assign rspValid  = st_r.rv;
  assign rspData   = st_r.rd;
endmodule

// >>> dv/sspi_monitor.sv
// Link assertions between host and device ends
`timescale 1ns/1ps
module sspi_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link signals
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic misoO,
  input wire logic misoOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Windows allow for the device synchroniser delay
  oe_idle_a: assert property (csN [*6] |-> !misoOe)
    else $error("miso driven while idle");
  oe_sel_a: assert property (!csN [*6] |-> misoOe)
    else $error("miso not driven in frame");
  miso_off_a: assert property (!misoOe |-> !misoO)
    else $error("miso level while released");
  sck_edge_a: assert property ($changed(csN) |-> !sck && !$past(sck))
    else $error("clock high at select edge");
  sck_idle_a: assert property (csN |-> !sck)
    else $error("clock active while idle");
  sck_high_a: assert property ($rose(sck) |-> sck [*4])
    else $error("clock high phase short");
  // Output may only move after a rising clock edge
  miso_hold_a: assert property ($fell(sck) && !csN |->
    ##2 $stable(misoO) [*4])
    else $error("miso moved away from rise");
  frame_len_a: assert property ($fell(csN) |-> ##[128:144] $rose(csN))
    else $error("frame length wrong");
endmodule

// >>> dv/switch_spi_slave_port_tb.sv
// Bench: host end driving the device end over the link
`timescale 1ns/1ps
module switch_spi_slave_port_tb;
  logic       clk, rst_n, reqValid, reqReady, rspValid;
  logic       cmdValid, cmdWd;
  logic [7:0] reqData, rspData, statusIn;
  logic [3:0] cmdAddr, cmdCfg;
  logic [2:0] cmdReg;
  int         fail_count, n_tests, cyc;

  sspi_if link ();
  sspi_host sspi_host_inst (.clk(clk), .rst_n(rst_n), .link(link.host),
    .reqValid(reqValid), .reqData(reqData), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData));
  sspi_device sspi_device_inst (.clk(clk), .rst_n(rst_n),
    .link(link.dev), .statusIn(statusIn), .cmdValid(cmdValid),
    .cmdWd(cmdWd), .cmdAddr(cmdAddr), .cmdReg(cmdReg), .cmdCfg(cmdCfg));
  sspi_monitor sspi_monitor_inst (.clk(clk), .rst_n(rst_n),
    .sck(link.sck), .csN(link.csN), .mosi(link.mosi),
    .misoO(link.misoO), .misoOe(link.misoOe));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One frame; status moves mid-frame, answer must keep the first one
  task xfer(input logic [7:0] d, input logic [7:0] st, input logic [7:0] s2);
    int i;
    int g;
    g = 0;
    statusIn = st;
    reqValid = 1'b1;
    reqData  = d;
    while (reqReady !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 reqValid = 1'b0;
    for (i = 0; i < 200 && g < 2; i++) begin
      @(posedge clk);
      #1;
      if (i == 20)
        statusIn = s2;
      g += int'(cmdValid === 1'b1) + int'(rspValid === 1'b1);
    end
    chk("rsp", rspData, st);
    chk("cmd", {cmdWd, cmdReg, cmdCfg}, d);
    chk("addr", {4'h0, cmdAddr}, {4'h0, d[7:4]});
    chk("done", g[7:0], 8'h02);
  endtask

  // Back-to-back frames through every register select
  task t_words;
    for (int k = 0; k < 8; k++)
      xfer({k[0], k[2:0], 4'(k * 3)}, 8'(k * 37 + 90), 8'(k * 37 + 90));
  endtask

  // Late status change must not leak into the answer
  task t_late;
    xfer(8'h3c, 8'hc3, 8'h18);
  endtask

  // Reset in mid-frame: link idles, next frame is whole again
  task t_reset;
    reqValid = 1'b1;
    reqData  = 8'h96;
    repeat (30) @(posedge clk);
    #1 chk("oeOn", {7'h0, link.misoOe}, 8'h01);
    rst_n    = 1'b0;
    reqValid = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b1;
    chk("oeOff", {7'h0, link.misoOe}, 8'h00);
    chk("csIdle", {7'h0, link.csN}, 8'h01);
    xfer(8'h69, 8'h5b, 8'h5b);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim;
    end
  end

  // Reset, scenarios, verdict
  initial begin
    rst_n    = 1'b0;
    reqValid = 1'b0;
    reqData  = 8'h00;
    statusIn = 8'h00;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_words;
    t_late;
    t_reset;
    end_sim;
  end
endmodule
